//--- logic/osw_defs.svh
`ifndef OSW_DEFS_SVH
`define OSW_DEFS_SVH

// ****************************************
// Register map (word index on the plain port)
// ****************************************
`define OSW_ADDR_CTRL      4'h0
`define OSW_ADDR_KEY       4'h1

// ****************************************
// Control register field positions
// ****************************************
`define OSW_CUR_HI         14
`define OSW_CUR_LO         12
`define OSW_NEW_HI         10
`define OSW_NEW_LO         8
`define OSW_CF_BIT         3
`define OSW_REQ_BIT        0

// ****************************************
// Reset values and unlock keys
// ****************************************
`define OSW_RST_OSC        3'h0
`define OSW_KEY_FIRST      16'h00A5
`define OSW_KEY_SECOND     16'h005A

// ****************************************
// Timing
// ****************************************
`define OSW_CLK_NS         20
`define OSW_SWITCH_NS      200
`define OSW_SWITCH_CYC     ((`OSW_SWITCH_NS + `OSW_CLK_NS - 1) / `OSW_CLK_NS)

`endif

//--- logic/osw_pkg.sv
`default_nettype none

package osw_pkg;

    // Oscillator source codes held in the select fields
    typedef enum logic [2:0] {
        OSW_SRC_FRC      = 3'b000,
        OSW_SRC_FRC_PLL  = 3'b001,
        OSW_SRC_PRI      = 3'b010,
        OSW_SRC_PRI_PLL  = 3'b011,
        OSW_SRC_BACKUP_INTERNAL_RC     = 3'b100,
        OSW_SRC_LPRC     = 3'b101,
        OSW_SRC_RSVD     = 3'b110,
        OSW_SRC_FRC_DIV  = 3'b111
    } osw_src_t;

    // Switch sequencer states
    typedef enum logic [1:0] {
        OSW_ST_IDLE = 2'b00,
        OSW_ST_WAIT = 2'b01
    } osw_state_t;

endpackage

`default_nettype wire

//--- logic/osw_switch_timer.sv
`timescale 1ns/1ps
`default_nettype none

module osw_switch_timer #(
    parameter int unsigned COUNT = 10,
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_sys_rst,
    // Control
    input  wire logic i_start,
    // Status
    output var  logic o_expired
);

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;
    logic             exp_next;

    // Count down from the settle time; expired stays high until the next start
    assign cnt_next = i_start ? WIDTH'(COUNT) : (cnt_reg != '0) ? cnt_reg - WIDTH'(1) : cnt_reg;
    assign exp_next = !i_start && (cnt_next == '0);

    // ****************************************
    // Counter registers
    // ****************************************
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cnt_reg   <= '0;
            o_expired <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            o_expired <= exp_next;
        end
    end

endmodule

`default_nettype wire

//--- logic/osw_control.sv
// Behaviour
// - Clock-fail flag sets on monitor failure, holds until software clears it.
// - Software sets switch request; hardware clears it when the switch completes.
// - Control register writes take effect only right after the two-key unlock.
// - Control register resets only on power-on reset, not on warm reset.
// - Fast RC failure forces the current-oscillator field to the backup RC code.
// - Backup RC code written into the new-oscillator field is rejected.
// - New-oscillator field at bits 10:8 writable only while clock config unlocked.
// - Bits 4, 2 and 1 read zero and ignore writes.
//
// The address map and the address-and-strobe port were decided locally.
`include "osw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module osw_control #(
    parameter int unsigned ADDR_W = 4
) (
    // Clock and resets
    input  wire logic              i_sys_clk,
    input  wire logic              i_sys_rst,
    input  wire logic              i_warm_rst,
    // Register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [15:0]       i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output var  logic [15:0]       o_rdata,
    // Clock sources and monitors
    input  wire logic              i_cfg_locked,
    input  wire logic              i_failsafe_clock_monitor_fail,
    input  wire logic              i_frc_fail,
    input  wire logic              i_new_src_ready,
    // Clock selection out
    output var  osw_pkg::osw_src_t o_cur_osc,
    output var  logic              o_switch_busy,
    output var  logic              o_clock_fail
);
    import osw_pkg::*;

    localparam int unsigned TMR_W = 8;

    // ****************************************
    // State
    // ****************************************
    osw_src_t   cur_reg;
    osw_src_t   cur_next;
    osw_src_t   new_reg;
    osw_src_t   new_next;
    logic       cf_reg;
    logic       cf_next;
    logic       req_reg;
    logic       req_next;
    logic       key1_reg;
    logic       key1_next;
    logic       unl_reg;
    logic       unl_next;
    osw_state_t st_reg;
    osw_state_t st_next;
    logic [15:0] rdata_next;

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic       sel_ctrl  = (i_addr == ADDR_W'(`OSW_ADDR_CTRL));
    wire logic       sel_key   = (i_addr == ADDR_W'(`OSW_ADDR_KEY));
    wire logic       key_wr    = i_wr && sel_key;
    wire logic       ctrl_wr   = i_wr && sel_ctrl;
    // Writes without a fresh unlock are dropped silently
    wire logic       ctrl_ok   = ctrl_wr && unl_reg && !i_warm_rst;
    wire osw_src_t   wr_src    = osw_src_t'(i_wdata[`OSW_NEW_HI:`OSW_NEW_LO]);
    wire logic       wr_req    = i_wdata[`OSW_REQ_BIT];
    wire logic       wr_cf     = i_wdata[`OSW_CF_BIT];

    // Field write qualifiers
    wire logic       new_wr_ok = ctrl_ok && !i_cfg_locked
                                 && (wr_src != OSW_SRC_BACKUP_INTERNAL_RC);

    // ****************************************
    // Switch sequencer
    // ****************************************
    logic tmr_expired;
    // Start pulses once per request, in the last idle cycle
    wire logic start    = (st_reg == OSW_ST_IDLE) && req_reg;
    wire logic complete = (st_reg == OSW_ST_WAIT) && tmr_expired && i_new_src_ready;

    // Settle counter; also keeps a new request from finishing in one cycle
    // Warm reset restarts the count, so an interrupted switch settles again
    osw_switch_timer #(
        .COUNT (`OSW_SWITCH_CYC),
        .WIDTH (TMR_W)
    ) u_timer (
        .i_sys_clk (i_sys_clk),
        .i_sys_rst (i_sys_rst || i_warm_rst),
        .i_start   (start),
        .o_expired (tmr_expired)
    );

    // Next state of the sequencer
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            OSW_ST_IDLE: begin
                if (req_reg) begin
                    st_next = OSW_ST_WAIT;
                end
            end
            OSW_ST_WAIT: begin
                if (complete) begin
                    st_next = OSW_ST_IDLE;
                end
            end
            default: begin
                st_next = OSW_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // Field next values
    // ****************************************
    // Monitor event beats a software clear in the same cycle
    assign cf_next  = i_failsafe_clock_monitor_fail || (cf_reg && !(ctrl_ok && !wr_cf));

    // A new request written in the completion cycle is kept
    assign req_next = (ctrl_ok && wr_req) ? 1'b1 : complete ? 1'b0 : req_reg;

    // The PLL-to-PLL ban is left to software; no guard here
    assign new_next = new_wr_ok ? wr_src : new_reg;

    // Fast RC failure outranks a completing switch
    assign cur_next = i_frc_fail ? OSW_SRC_BACKUP_INTERNAL_RC
                    : complete ? new_reg : cur_reg;

    // Two keys in consecutive writes open one control write
    // A stray write between the keys aborts, so one errant store cannot unlock
    assign key1_next = key_wr ? (i_wdata == `OSW_KEY_FIRST) : i_wr ? 1'b0 : key1_reg;
    assign unl_next  = (key_wr && key1_reg && (i_wdata == `OSW_KEY_SECOND)) ? 1'b1
                     : ctrl_wr ? 1'b0 : unl_reg;

    // Read mux; bits 15, 11, 7 to 4 and 2 to 1 read zero
    // Every field not listed keeps the zero that the mux starts from
    always_comb begin
        rdata_next = 16'h0000;
        if (i_rd && sel_ctrl) begin
            rdata_next[`OSW_CUR_HI:`OSW_CUR_LO] = cur_reg;
            rdata_next[`OSW_NEW_HI:`OSW_NEW_LO] = new_reg;
            rdata_next[`OSW_CF_BIT]             = cf_reg;
            rdata_next[`OSW_REQ_BIT]            = req_reg;
        end else if (i_rd && sel_key) begin
            rdata_next[0] = unl_reg;
        end
    end

    // ****************************************
    // Power-on-only register fields
    // ****************************************
    // Warm reset deliberately absent: the control register survives it
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            cur_reg <= osw_src_t'(`OSW_RST_OSC);
            new_reg <= osw_src_t'(`OSW_RST_OSC);
            cf_reg  <= 1'b0;
            req_reg <= 1'b0;
        end else begin
            cur_reg <= cur_next;
            new_reg <= new_next;
            cf_reg  <= cf_next;
            req_reg <= req_next;
        end
    end

    // ****************************************
    // Sequencer, unlock and output registers
    // ****************************************
    // Any reset closes the unlock and restarts the sequencer
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_warm_rst) begin
            st_reg   <= OSW_ST_IDLE;
            key1_reg <= 1'b0;
            unl_reg  <= 1'b0;
        end else begin
            st_reg   <= st_next;
            key1_reg <= key1_next;
            unl_reg  <= unl_next;
        end
    end

    // Outputs mirror the next values so they stay in step with the fields
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            o_rdata       <= 16'h0000;
            o_cur_osc     <= osw_src_t'(`OSW_RST_OSC);
            o_switch_busy <= 1'b0;
            o_clock_fail  <= 1'b0;
        end else begin
            o_rdata       <= rdata_next;
            o_cur_osc     <= cur_next;
            o_switch_busy <= req_next;
            o_clock_fail  <= cf_next;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    // Properties watch the registers; outputs only where they mirror one
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_key_pair;
        key_wr && (i_wdata == `OSW_KEY_FIRST) && !i_warm_rst
        ##1 key_wr && (i_wdata == `OSW_KEY_SECOND) && !i_warm_rst;
    endsequence

    // Settle time: no completion in the first eight waiting cycles
    sequence s_wait_early;
        (!complete) [*8];
    endsequence

    sequence s_req_taken;
        (st_reg == OSW_ST_IDLE) && req_reg && !i_warm_rst ##1 (st_reg == OSW_ST_WAIT);
    endsequence

    a_cf_sets: assert property (i_failsafe_clock_monitor_fail |=> cf_reg && o_clock_fail)
        else $error("clock fail flag not set");

    a_cf_holds: assert property (cf_reg && !(ctrl_ok && !wr_cf) |=> cf_reg)
        else $error("clock fail flag lost");

    a_unlock_opens: assert property (s_key_pair |=> unl_reg)
        else $error("key pair did not unlock");

    a_locked_drop: assert property (ctrl_wr && !unl_reg |=> $stable(new_reg))
        else $error("write accepted while locked");

    a_req_clears: assert property (s_req_taken ##[1:300] complete
        |=> !req_reg || ($past(ctrl_ok) && $past(wr_req)))
        else $error("request not cleared on completion");

    a_warm_keeps: assert property (i_warm_rst |=> $stable(new_reg))
        else $error("warm reset changed control field");

    a_frc_force: assert property (i_frc_fail |=> cur_reg == OSW_SRC_BACKUP_INTERNAL_RC
        && o_cur_osc == OSW_SRC_BACKUP_INTERNAL_RC)
        else $error("current field not forced to backup");

    a_no_backup: assert property (new_reg != OSW_SRC_BACKUP_INTERNAL_RC)
        else $error("backup code in new field");

    a_cfg_lock: assert property (i_cfg_locked |=> $stable(new_reg))
        else $error("new field changed while locked");

    a_rsvd_zero: assert property (i_rd |=> o_rdata[15] == 1'b0 && o_rdata[11] == 1'b0
        && o_rdata[7:4] == 4'h0 && o_rdata[2:1] == 2'b00)
        else $error("reserved bits read non-zero");

    a_cur_load: assert property (complete && !i_frc_fail |=> cur_reg == $past(new_reg))
        else $error("current field not loaded");

    // Nothing sets the fail flag but the monitor
    a_cf_quiet: assert property (!cf_reg && !i_failsafe_clock_monitor_fail |=> !cf_reg)
        else $error("clock fail flag set without failure");

    // Writing zero clears the flag when no new failure arrives
    a_cf_clears: assert property (cf_reg && ctrl_ok && !wr_cf && !i_failsafe_clock_monitor_fail |=> !cf_reg)
        else $error("clock fail flag not cleared");

    // An accepted write of one raises the request
    a_req_sets: assert property (ctrl_ok && wr_req |=> req_reg && o_switch_busy)
        else $error("switch request not taken");

    // A switch may not finish before the settle time has run
    a_switch_min: assert property (s_req_taken |-> s_wait_early)
        else $error("switch completed too early");

    // Any control write, taken or not, closes the unlock
    a_unlock_closes: assert property (ctrl_wr |=> !unl_reg)
        else $error("unlock survived a control write");

    // A write elsewhere between the keys aborts the pair
    a_key_abort: assert property (i_wr && !key_wr |=> !key1_reg)
        else $error("first key survived a stray write");

    // Warm reset drops a half-made or open unlock
    a_warm_unlock: assert property (i_warm_rst |=> !unl_reg && !key1_reg)
        else $error("unlock survived warm reset");

    // Warm reset leaves the status fields where they were
    a_warm_fields: assert property (i_warm_rst && !i_frc_fail && !i_failsafe_clock_monitor_fail && !complete
        |=> $stable(cur_reg) && $stable(cf_reg))
        else $error("warm reset changed status field");

    // An open write lands in the new field unchanged
    a_new_accept: assert property (new_wr_ok |=> new_reg == $past(wr_src))
        else $error("new field write lost");

    // Unused bits of the key word read zero
    a_key_read: assert property (i_rd && sel_key |=> o_rdata[15:1] == 15'h0000)
        else $error("key word upper bits non-zero");

    // Read data stand for one cycle only
    a_rd_idle: assert property (!i_rd |=> o_rdata == 16'h0000)
        else $error("read data outlived its cycle");

    // The current field moves only on completion or fast RC loss
    a_cur_hold: assert property (!complete && !i_frc_fail |=> $stable(cur_reg))
        else $error("current field changed on its own");

endmodule

`default_nettype wire

//--- dv/osw_osc_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Clock sources and failure monitors
// ****************************************
module osw_osc_model (
    // Clock
    input  wire logic       i_sys_clk,
    // Switch handshake
    input  wire logic       i_busy,
    input  wire logic [4:0] i_delay,
    output var  logic       o_ready,
    // Failure injection from the bench
    input  wire logic       i_kill_failsafe_clock_monitor,
    input  wire logic       i_kill_frc,
    output var  logic       o_failsafe_clock_monitor_fail,
    output var  logic       o_frc_fail
);
    logic [4:0] wait_reg = 5'h00;

    // Target settles i_delay cycles after the request shows; slow sources stretch the switch
    always_ff @(posedge i_sys_clk) begin
        if (!i_busy) begin
            wait_reg <= 5'h00;
        end else if (wait_reg != i_delay) begin
            wait_reg <= wait_reg + 5'h01;
        end
    end
    assign o_ready = i_busy && (wait_reg == i_delay);

    // Monitors report a failure one cycle after it is injected
    always_ff @(posedge i_sys_clk) begin
        o_failsafe_clock_monitor_fail <= i_kill_failsafe_clock_monitor;
        o_frc_fail <= i_kill_frc;
    end
endmodule

`default_nettype wire

//--- dv/oscillator_switch_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module oscillator_switch_control_tb_top;
    import osw_pkg::*;
    typedef struct {logic [15:0] data; logic lock; logic [4:0] dly; logic [15:0] exp;} osw_row_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        warm = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        locked = 1'b0;
    logic        kill_failsafe_clock_monitor = 1'b0;
    logic        kill_frc = 1'b0;
    logic [4:0]  delay = 5'h00;
    logic [15:0] rdata;
    logic        failsafe_clock_monitor, fast_internal_rc, ready, busy, cf;
    osw_src_t    cur;
    int          num_errors = 0;
    int          checks_done = 0;
    // Rows: control write after unlock, lock level, source delay, readback once settled
    // The sequence never steps straight between the two PLL modes
    osw_row_t rows [5] = '{
        '{16'h0301, 1'b0, 5'h00, 16'h3300},
        '{16'h0016, 1'b0, 5'h00, 16'h3000},
        '{16'h0401, 1'b0, 5'h03, 16'h0000},
        '{16'h0500, 1'b1, 5'h00, 16'h0000},
        '{16'h0501, 1'b0, 5'h14, 16'h5500}
    };

    osw_control DUT (.i_sys_clk(clk), .i_sys_rst(rst), .i_warm_rst(warm), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cfg_locked(locked),
        .i_failsafe_clock_monitor_fail(failsafe_clock_monitor), .i_frc_fail(fast_internal_rc), .i_new_src_ready(ready), .o_cur_osc(cur),
        .o_switch_busy(busy), .o_clock_fail(cf));
    osw_osc_model PARTNER (.i_sys_clk(clk), .i_busy(busy), .i_delay(delay), .o_ready(ready),
        .i_kill_failsafe_clock_monitor(kill_failsafe_clock_monitor), .i_kill_frc(kill_frc), .o_failsafe_clock_monitor_fail(failsafe_clock_monitor), .o_frc_fail(fast_internal_rc));

    // Free-running 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Keys go out back to back, the strobe held high across both
    task automatic unlock();
        @(posedge clk);
        addr <= 4'h1;
        wdata <= 16'h00A5;
        wr <= 1'b1;
        @(posedge clk);
        wdata <= 16'h005A;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Switch time has no upper bound, so the wait is capped
    task automatic settle();
        repeat (3) @(posedge clk);
        for (int i = 0; i < 100 && busy !== 1'b0; i++) @(negedge clk);
        #1 chk({15'h0000, busy}, 16'h0000);
    endtask
    task automatic fail(input logic frc_side);
        @(posedge clk);
        kill_failsafe_clock_monitor <= !frc_side;
        kill_frc <= frc_side;
        @(posedge clk);
        kill_failsafe_clock_monitor <= 1'b0;
        kill_frc <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic print_verdict();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rd_chk(4'h0, 16'h0000);
        rd_chk(4'h9, 16'h0000);
        foreach (rows[n]) begin
            locked <= rows[n].lock;
            delay <= rows[n].dly;
            unlock();
            wr_reg(4'h0, rows[n].data);
            #1 chk({15'h0000, busy}, {15'h0000, rows[n].data[0]});
            settle();
            rd_chk(4'h0, rows[n].exp);
        end
        locked <= 1'b0;
        // A bare write, and a key pair split by a stray write, must both be ignored
        wr_reg(4'h0, 16'h0201);
        wr_reg(4'h1, 16'h00A5);
        wr_reg(4'h7, 16'h0000);
        wr_reg(4'h1, 16'h005A);
        rd_chk(4'h1, 16'h0000);
        wr_reg(4'h0, 16'h0201);
        rd_chk(4'h0, 16'h5500);
        // Key word opens, then one control write closes it again
        unlock();
        rd_chk(4'h1, 16'h0001);
        wr_reg(4'h0, 16'h0500);
        rd_chk(4'h1, 16'h0000);
        // Flag holds until software writes it as zero
        fail(1'b0);
        repeat (10) @(posedge clk);
        rd_chk(4'h0, 16'h5508);
        chk({15'h0000, cf}, 16'h0001);
        unlock();
        wr_reg(4'h0, 16'h0500);
        rd_chk(4'h0, 16'h5500);
        chk({15'h0000, cf}, 16'h0000);
        // Fast RC loss drops the current source to the backup
        fail(1'b1);
        rd_chk(4'h0, 16'h4500);
        chk({13'h0000, cur}, {13'h0000, OSW_SRC_BACKUP_INTERNAL_RC});
        // Warm reset leaves the register alone, power-on reset clears it
        @(posedge clk);
        warm <= 1'b1;
        repeat (2) @(posedge clk);
        warm <= 1'b0;
        rd_chk(4'h0, 16'h4500);
        chk({13'h0000, cur}, {13'h0000, OSW_SRC_BACKUP_INTERNAL_RC});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(4'h0, 16'h0000);
        print_verdict();
    end

    // Whole run takes well under 2000 cycles
    initial begin
        #100000;
        num_errors++;
        print_verdict();
    end
endmodule

`default_nettype wire
